// File: rtl/pci_top.sv
/*
  Pin change interrupt controller with a classic Wishbone register port.
  Assumes one 10 MHz clock, synchronous active-low reset, and an upstream
  CPU that samples irq_out and wake_out as levels.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Second port upper pins set flags on enabled edges.
// - Second port bits three to zero read zero.
// - Third port rise enable arms rising detection.
// - Third port fall enable arms falling detection.
// - Third port flag sets on enabled edge.
// - Flags set by hardware, cleared by software.
// - All enables and flags reset to zero.
// - Top bits, second port only on large package.
// - Summary interrupt gated by master enable only.
// - Summary flag is read-only OR of flags.
// - Edge during flag write keeps flag set.
// - Change event wakes device when master enabled.
module pci_top #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic                 mclk_in,
  input  wire logic                 reset_n_in,
  input  wire pci_pkg::pci_wb_req_t wb_req_in,
  output pci_pkg::pci_wb_rsp_t      wb_rsp_out,
  input  wire pci_pkg::pci_pins_t   pins_in,
  output logic                      irq_out,
  output logic                      wake_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  a_rise;
    logic [7:0]  a_fall;
    logic [7:0]  a_flag;
    logic [7:0]  b_rise;
    logic [7:0]  b_fall;
    logic [7:0]  b_flag;
    logic [7:0]  c_rise;
    logic [7:0]  c_fall;
    logic [7:0]  c_flag;
    logic        master_en;
    logic [1:0]  evt_status;
    logic [1:0]  evt_mask;
    logic        ack;
    logic [31:0] rdata;
  } pci_state_t;

  pci_state_t st_q;
  pci_state_t st_d;

  // Unimplemented bits are masked at the write and again at detection.
  localparam logic [7:0] MASK_A = LARGE_PACKAGE ? pci_pkg::PORTA_MASK_LARGE : pci_pkg::PORTA_MASK_SMALL;
  localparam logic [7:0] MASK_B = LARGE_PACKAGE ? pci_pkg::PORTB_MASK_LARGE : pci_pkg::REG_RESET;
  localparam logic [7:0] MASK_C = LARGE_PACKAGE ? pci_pkg::PORTC_MASK_LARGE : pci_pkg::PORTC_MASK_SMALL;

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  logic [7:0] rise_a;
  logic [7:0] fall_a;
  logic [7:0] rise_b;
  logic [7:0] fall_b;
  logic [7:0] rise_c;
  logic [7:0] fall_c;

  pci_edge_detect u_edge_a (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .pins_in    (pins_in.a),
    .rise_out   (rise_a),
    .fall_out   (fall_a)
  );

  pci_edge_detect u_edge_b (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .pins_in    (pins_in.b),
    .rise_out   (rise_b),
    .fall_out   (fall_b)
  );

  pci_edge_detect u_edge_c (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .pins_in    (pins_in.c),
    .rise_out   (rise_c),
    .fall_out   (fall_c)
  );

  logic [7:0] hit_a;
  logic [7:0] hit_b;
  logic [7:0] hit_c;
  logic       summary;
  logic       any_hit;

  assign hit_a   = ((rise_a & st_q.a_rise) | (fall_a & st_q.a_fall)) & MASK_A;
  assign hit_b   = ((rise_b & st_q.b_rise) | (fall_b & st_q.b_fall)) & MASK_B;
  assign hit_c   = ((rise_c & st_q.c_rise) | (fall_c & st_q.c_fall)) & MASK_C;
  assign summary = |{st_q.a_flag, st_q.b_flag, st_q.c_flag};
  assign any_hit = |{hit_a, hit_b, hit_c};

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic       access;
  logic       wr;
  logic [7:0] wbyte;

  assign access = wb_req_in.cyc & wb_req_in.stb & ~st_q.ack;
  assign wr     = access & wb_req_in.we & wb_req_in.sel[0];
  assign wbyte  = wb_req_in.dat[7:0];

  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] hit,
                                           input logic       do_wr,
                                           input logic [7:0] val,
                                           input logic [7:0] mask);
    logic [7:0] base;
    base = do_wr ? (cur & val) : cur;
    // A set in the same cycle as the write wins over the clear.
    return (base | hit) & mask;
  endfunction : flag_next

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    st_d.ack = access;
    if (wr) begin
      case (wb_req_in.adr)
        pci_pkg::PORTA_RISE_ENABLE_OFS: st_d.a_rise = wbyte & MASK_A;
        pci_pkg::PORTA_FALL_ENABLE_OFS: st_d.a_fall = wbyte & MASK_A;
        pci_pkg::PORTB_RISE_ENABLE_OFS: st_d.b_rise = wbyte & MASK_B;
        pci_pkg::PORTB_FALL_ENABLE_OFS: st_d.b_fall = wbyte & MASK_B;
        pci_pkg::PORTC_RISE_ENABLE_OFS: st_d.c_rise = wbyte & MASK_C;
        pci_pkg::PORTC_FALL_ENABLE_OFS: st_d.c_fall = wbyte & MASK_C;
        pci_pkg::IRQ_CONTROL_OFS:       st_d.master_en = wbyte[pci_pkg::MASTER_EN_BIT];
        pci_pkg::IRQ_MASK_OFS:          st_d.evt_mask = wbyte[1:0];
        default: begin
        end
      endcase
    end
    st_d.a_flag = flag_next(st_q.a_flag, hit_a, wr && wb_req_in.adr == pci_pkg::PORTA_CHANGE_FLAGS_OFS,
                            wbyte, MASK_A);
    st_d.b_flag = flag_next(st_q.b_flag, hit_b, wr && wb_req_in.adr == pci_pkg::PORTB_CHANGE_FLAGS_OFS,
                            wbyte, MASK_B);
    st_d.c_flag = flag_next(st_q.c_flag, hit_c, wr && wb_req_in.adr == pci_pkg::PORTC_CHANGE_FLAGS_OFS,
                            wbyte, MASK_C);
    // Event status is write-one-to-clear; a new event in the same cycle wins.
    if (wr && wb_req_in.adr == pci_pkg::IRQ_STATUS_OFS) begin
      st_d.evt_status = st_q.evt_status & ~wbyte[1:0];
    end
    if (any_hit) begin
      st_d.evt_status[pci_pkg::EVT_SUMMARY_BIT] = 1'b1;
    end
    if (any_hit && st_q.master_en) begin
      st_d.evt_status[pci_pkg::EVT_WAKE_BIT] = 1'b1;
    end
    st_d.rdata = 32'h0000_0000;
    if (access && !wb_req_in.we) begin
      case (wb_req_in.adr)
        pci_pkg::PORTA_RISE_ENABLE_OFS:  st_d.rdata[7:0] = st_q.a_rise;
        pci_pkg::PORTA_FALL_ENABLE_OFS:  st_d.rdata[7:0] = st_q.a_fall;
        pci_pkg::PORTA_CHANGE_FLAGS_OFS: st_d.rdata[7:0] = st_q.a_flag;
        pci_pkg::PORTB_RISE_ENABLE_OFS:  st_d.rdata[7:0] = st_q.b_rise;
        pci_pkg::PORTB_FALL_ENABLE_OFS:  st_d.rdata[7:0] = st_q.b_fall;
        pci_pkg::PORTB_CHANGE_FLAGS_OFS: st_d.rdata[7:0] = st_q.b_flag;
        pci_pkg::PORTC_RISE_ENABLE_OFS:  st_d.rdata[7:0] = st_q.c_rise;
        pci_pkg::PORTC_FALL_ENABLE_OFS:  st_d.rdata[7:0] = st_q.c_fall;
        pci_pkg::PORTC_CHANGE_FLAGS_OFS: st_d.rdata[7:0] = st_q.c_flag;
        pci_pkg::IRQ_CONTROL_OFS: begin
          st_d.rdata[pci_pkg::MASTER_EN_BIT] = st_q.master_en;
          st_d.rdata[pci_pkg::SUMMARY_BIT]   = summary;
        end
        pci_pkg::IRQ_STATUS_OFS:  st_d.rdata[1:0] = st_q.evt_status;
        pci_pkg::IRQ_MASK_OFS:    st_d.rdata[1:0] = st_q.evt_mask;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      st_q.a_rise     <= pci_pkg::REG_RESET;
      st_q.a_fall     <= pci_pkg::REG_RESET;
      st_q.a_flag     <= pci_pkg::REG_RESET;
      st_q.b_rise     <= pci_pkg::REG_RESET;
      st_q.b_fall     <= pci_pkg::REG_RESET;
      st_q.b_flag     <= pci_pkg::REG_RESET;
      st_q.c_rise     <= pci_pkg::REG_RESET;
      st_q.c_fall     <= pci_pkg::REG_RESET;
      st_q.c_flag     <= pci_pkg::REG_RESET;
      st_q.master_en  <= 1'b0;
      st_q.evt_status <= pci_pkg::EVT_RESET;
      st_q.evt_mask   <= pci_pkg::EVT_RESET;
      st_q.ack        <= 1'b0;
      st_q.rdata      <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Port flags keep setting with the master enable clear; it gates wake_out, the summary term of irq_out and the wake status bit.
  assign irq_out        = (st_q.master_en & summary) | |(st_q.evt_status & st_q.evt_mask);
  assign wake_out       = st_q.master_en & summary;
  assign wb_rsp_out.ack = st_q.ack;
  assign wb_rsp_out.dat = st_q.rdata;

endmodule : pci_top

`default_nettype wire

// File: rtl/pci_pkg.sv
/*
  Package for the pin change interrupt block: register offsets, field masks,
  reset values and the bus carrier structs.
  Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
*/
package pci_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORTA_RISE_ENABLE_OFS  = 8'h00;
  localparam logic [7:0] PORTA_FALL_ENABLE_OFS  = 8'h04;
  localparam logic [7:0] PORTA_CHANGE_FLAGS_OFS = 8'h08;
  localparam logic [7:0] PORTB_RISE_ENABLE_OFS  = 8'h0c;
  localparam logic [7:0] PORTB_FALL_ENABLE_OFS  = 8'h10;
  localparam logic [7:0] PORTB_CHANGE_FLAGS_OFS = 8'h14;
  localparam logic [7:0] PORTC_RISE_ENABLE_OFS  = 8'h18;
  localparam logic [7:0] PORTC_FALL_ENABLE_OFS  = 8'h1c;
  localparam logic [7:0] PORTC_CHANGE_FLAGS_OFS = 8'h20;
  localparam logic [7:0] IRQ_CONTROL_OFS        = 8'h24;
  localparam logic [7:0] IRQ_STATUS_OFS         = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS           = 8'h2c;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PORTA_MASK_SMALL = 8'h3f;
  localparam logic [7:0] PORTA_MASK_LARGE = 8'hff;
  localparam logic [7:0] PORTB_MASK_LARGE = 8'hf0;
  localparam logic [7:0] PORTC_MASK_SMALL = 8'h3f;
  localparam logic [7:0] PORTC_MASK_LARGE = 8'hff;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int         MASTER_EN_BIT    = 0;
  localparam int         SUMMARY_BIT      = 1;
  localparam int         EVT_SUMMARY_BIT  = 0;
  localparam int         EVT_WAKE_BIT     = 1;
  localparam logic [1:0] EVT_RESET        = 2'h0;
  localparam logic [2:0] SYNC_RESET       = 3'h0;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pci_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pci_wb_rsp_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } pci_pins_t;

endpackage : pci_pkg

// File: rtl/pci_edge_detect.sv
/*
  Synchroniser and edge detector for one port of eight pins.
  Assumes the pins are asynchronous to mclk_in; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pci_edge_detect (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] pins_in,
  output logic      [7:0] rise_out,
  output logic      [7:0] fall_out
);

  // ---------------------------------------------------------------------------
  // Per-pin synchroniser
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sync;
    logic [2:0] fill;
    logic       level;
    logic       primed;
  } pci_bit_state_t;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pci_bit_state_t st_q;
      pci_bit_state_t st_d;
      logic           agree;
      // A change counts only once stages 1 and 2 agree, so a one-cycle glitch is dropped.
      assign agree = (st_q.sync[1] == st_q.sync[2]);
      always_comb begin
        st_d      = st_q;
        st_d.sync = {st_q.sync[1:0], pins_in[gi]};
        st_d.fill = {st_q.fill[1:0], 1'b1};
        if (st_q.fill[2] && agree) begin
          st_d.level  = st_q.sync[2];
          st_d.primed = 1'b1;
        end
      end
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          st_q.sync   <= pci_pkg::SYNC_RESET;
          st_q.fill   <= pci_pkg::SYNC_RESET;
          st_q.level  <= 1'b0;
          st_q.primed <= 1'b0;
        end else begin
          st_q <= st_d;
        end
      end
      // Edges are held back after reset until the pin level is known, so a high pin is no false edge.
      assign rise_out[gi] = st_q.primed & agree & st_q.sync[2] & ~st_q.level;
      assign fall_out[gi] = st_q.primed & agree & ~st_q.sync[2] & st_q.level;
    end
  endgenerate

endmodule : pci_edge_detect

`default_nettype wire

// File: testbench/pci_checker.sv
/*
  Port assertions for the pin change interrupt block.
  Assumes it is bound to pci_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_checker (
  input wire logic                 mclk_in,
  input wire logic                 reset_n_in,
  input wire pci_pkg::pci_wb_req_t wb_req_in,
  input wire pci_pkg::pci_wb_rsp_t wb_rsp_out,
  input wire pci_pkg::pci_pins_t   pins_in,
  input wire logic                 irq_out,
  input wire logic                 wake_out
);
  // ---------------------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence s_rd_b;
    s_take ##0 (!wb_req_in.we && (wb_req_in.adr inside {8'h0c, 8'h10, 8'h14}));
  endsequence
  // Seven quiet samples cover the synchroniser and flag latency with margin.
  sequence s_pins_quiet;
    $stable(pins_in)[*7];
  endsequence
  a_ack_one_cycle: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack) else $error("ack longer than one cycle");
  a_ack_after_take: assert property (s_take |=> wb_rsp_out.ack) else $error("request not acknowledged");
  a_ack_has_req: assert property ($rose(wb_rsp_out.ack) |-> $past(wb_req_in.cyc && wb_req_in.stb))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_rsp_out.ack |-> wb_rsp_out.dat == 32'h0) else $error("data outside ack");
  a_dat_upper_zero: assert property (wb_rsp_out.ack |-> wb_rsp_out.dat[31:8] == 24'h0) else $error("upper data set");
  a_portb_low_zero: assert property (s_rd_b |=> wb_rsp_out.dat[3:0] == 4'h0)
    else $error("second port low bits set");
  a_wake_needs_irq: assert property (wake_out |-> irq_out) else $error("wake without interrupt");
  a_reset_quiet: assert property ($rose(reset_n_in) |-> !wb_rsp_out.ack && !irq_out && !wake_out)
    else $error("outputs active after reset");
  a_irq_hold_quiet: assert property (s_pins_quiet ##0 !wb_rsp_out.ack |-> $stable(irq_out) && $stable(wake_out))
    else $error("interrupt moved without cause");
endmodule : pci_checker
bind pci_top pci_checker u_chk (.mclk_in, .reset_n_in, .wb_req_in, .wb_rsp_out, .pins_in, .irq_out, .wake_out);
`default_nettype wire

// File: testbench/pci_pin_model.sv
/*
  Model of the external drivers of the port pins.
  Assumes the bench gives the wanted levels; slow adds one cycle of lag.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_pin_model (
  input  wire logic               mclk_in,
  input  wire logic               slow_in,
  input  wire pci_pkg::pci_pins_t want_in,
  output var  pci_pkg::pci_pins_t pins_out
);
  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  pci_pkg::pci_pins_t hold_q = '0;
  initial pins_out = '0;
  always @(posedge mclk_in) begin
    hold_q <= want_in;
    pins_out <= slow_in ? hold_q : want_in;
  end
endmodule : pci_pin_model
`default_nettype wire

// File: testbench/pin_change_interrupt_test.sv
/*
  Self-checking bench for pci_top: bus tasks, a pin model and a read queue.
  Assumes the package, the pin model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_change_interrupt_test;
  // ---------------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------------
  logic                 mclk_in    = 1'b0;
  logic                 reset_n_in = 1'b0;
  logic                 slow       = 1'b0;
  pci_pkg::pci_wb_req_t req        = '0;
  pci_pkg::pci_wb_rsp_t rsp;
  pci_pkg::pci_pins_t   want       = 24'h00ff00;
  pci_pkg::pci_pins_t   pins;
  logic                 irq;
  logic                 wake;
  logic [8:0]           exp_q[$];
  logic [31:0]          seed       = 32'h44c7;
  logic [7:0]           rc, fc, p;
  int                   err_count  = 0;
  int                   num_checks = 0;
  always #50 mclk_in = ~mclk_in;
  pci_top #(.LARGE_PACKAGE(1'b1)) dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .wb_req_in(req),
    .wb_rsp_out(rsp), .pins_in(pins), .irq_out(irq), .wake_out(wake));
  pci_pin_model u_pins (.mclk_in(mclk_in), .slow_in(slow), .want_in(want), .pins_out(pins));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Read data is judged here, against the oldest note, at the ack edge.
  always @(posedge mclk_in) begin
    logic [8:0] e;
    if (rsp.ack === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      if (e[8]) chk("rdata", e[7:0], rsp.dat[7:0]);
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    int n;
    exp_q.push_back(e);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n == 50) chk("ack_wait", 8'h1, 8'h0);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge mclk_in);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0, {1'b1, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 9'h0);
  endtask : wr
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_count++;
    test_done();
  end
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 13; i++) rd(8'(i * 4), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      wr(8'(i * 4), 8'hff);
      rd(8'(i * 4), (i % 3 == 2) ? 8'h00 : (i / 3 == 1) ? 8'hf0 : 8'hff);
    end
    $display("test masks done");
    seed = xs(seed);
    rc = seed[7:0];
    seed = xs(seed);
    fc = seed[7:0];
    seed = xs(seed);
    p = seed[7:0];
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h18, rc);
    wr(8'h1c, fc);
    slow <= 1'b1;
    want <= {8'hff, 8'h0f, p};
    repeat (8) @(posedge mclk_in);
    rd(8'h08, 8'hff);
    rd(8'h14, 8'hf0);
    rd(8'h20, p & rc);
    rd(8'h24, 8'h02);
    chk("wake", 8'h0, {7'h0, wake});
    want.c <= 8'h00;
    repeat (8) @(posedge mclk_in);
    rd(8'h20, p & (rc | fc));
    $display("test edges done");
    wr(8'h24, 8'h01);
    rd(8'h24, 8'h03);
    chk("wake", 8'h1, {7'h0, wake});
    rd(8'h28, 8'h01);
    wr(8'h28, 8'h01);
    rd(8'h28, 8'h00);
    wr(8'h2c, 8'h02);
    wr(8'h08, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h24, 8'h01);
    chk("irq", 8'h0, {7'h0, irq});
    slow <= 1'b0;
    want.a <= 8'h00;
    repeat (8) @(posedge mclk_in);
    rd(8'h08, 8'h00);
    want.a <= 8'h01;
    repeat (8) @(posedge mclk_in);
    rd(8'h08, 8'h01);
    rd(8'h28, 8'h03);
    wr(8'h24, 8'h00);
    chk("irq", 8'h1, {7'h0, irq});
    chk("wake", 8'h0, {7'h0, wake});
    wr(8'h2c, 8'h00);
    chk("irq", 8'h0, {7'h0, irq});
    want.a <= 8'h03;
    repeat (4) @(posedge mclk_in);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h02);
    $display("test interrupt done");
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(8'h18, 8'h00);
    rd(8'h08, 8'h00);
    $display("test rerun reset done");
    test_done();
  end
endmodule : pin_change_interrupt_test
`default_nettype wire
